// >>> core/tfs_cfg.svh
// Purpose: Offsets, field positions, reset values and timing of the test frame source
// Assumes: 100 MHz core clock, one frame byte per clock
// Notes:   Byte address of a register is four times its index
`ifndef TFS_CFG_SVH
`define TFS_CFG_SVH

`define TFS_IDX_CTRL      6'h1D
`define TFS_IDX_PAYLOAD   6'h1E
`define TFS_IDX_CRCCNT    6'h17

`define TFS_B_EN          15
`define TFS_B_RUN         14
`define TFS_B_DUR         13
`define TFS_B_LEN_HI      12
`define TFS_B_LEN_LO      11
`define TFS_B_GAP         10
`define TFS_B_DA_HI       9
`define TFS_B_DA_LO       6
`define TFS_B_SA_HI       5
`define TFS_B_SA_LO       2
`define TFS_B_TXER        1
`define TFS_B_BADFCS      0

`define TFS_RST_CTRL      16'h0040
`define TFS_RST_PAYLOAD   16'h0000

`define TFS_LEN_00        14'd125
`define TFS_LEN_01        14'd64
`define TFS_LEN_10        14'd1518
`define TFS_LEN_11        14'd10000

`define TFS_CLK_NS        10
`define TFS_GAP_SHORT_NS  96
`define TFS_GAP_LONG_NS   8192
`define TFS_GAP_SHORT_CYC ((`TFS_GAP_SHORT_NS + `TFS_CLK_NS - 1) / `TFS_CLK_NS)
`define TFS_GAP_LONG_CYC  ((`TFS_GAP_LONG_NS + `TFS_CLK_NS - 1) / `TFS_CLK_NS)
`define TFS_BURST_FRAMES  30000000

`define TFS_PREAMBLE      8'h55
`define TFS_SFD           8'hD5
`define TFS_FIFO_DEPTH    8

`endif

// >>> core/tfs_pkg.sv
// Purpose: Types shared by the test frame source files
// Assumes: Constants live in tfs_cfg.svh
// Notes:   None
package tfs_pkg;

	typedef enum logic [4:0] {
		GEN_IDLE = 5'b00001,
		GEN_PRE  = 5'b00010,
		GEN_DATA = 5'b00100,
		GEN_FCS  = 5'b01000,
		GEN_GAP  = 5'b10000
	} tfs_gen_e;

	typedef struct packed {
		logic        dur;
		logic [1:0]  len;
		logic        gap;
		logic [3:0]  da;
		logic [3:0]  sa;
		logic        txer;
		logic        badfcs;
		logic [15:0] payload;
	} tfs_cfg_s;

	typedef struct packed {
		logic [7:0] data;
		logic       er;
		logic       last;
	} tfs_byte_s;

	typedef struct packed {
		logic        en;
		logic        run;
		logic        run_seen;
		tfs_cfg_s    live;
		tfs_cfg_s    sh;
		tfs_gen_e    st;
		logic [13:0] idx;
		logic [9:0]  gap;
		logic [24:0] nfr;
		logic        streaming;
		logic [7:0]  crccnt;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [7:0]  txd;
		logic        tx_en;
		logic        tx_er;
	} tfs_state_s;

endpackage : tfs_pkg

// >>> core/tfs_fifo.sv
// Purpose: Small FIFO with valid/ready on both sides and a flush
// Assumes: Depth is a power of two
// Notes:   Storage words are registers; head word read straight from them
`timescale 1ns/1ns
module tfs_fifo #(
	parameter int W = 10,
	parameter int D = 8
) (
	input  wire logic         i_core_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_flush,
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready,
	output logic              o_full
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wr;
	logic [AW-1:0] rd;
	logic [AW:0]   cnt;
	logic          push;
	logic          pop;

	assign o_full      = (cnt == (AW+1)'(D));
	assign o_in_ready  = !o_full;
	assign o_out_valid = (cnt != '0);
	assign o_out_data  = mem[rd];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem[wr] <= i_in_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr  <= '0;
			rd  <= '0;
			cnt <= '0;
		end else if (i_flush) begin
			wr  <= '0;
			rd  <= '0;
			cnt <= '0;
		end else begin
			if (push) begin
				wr <= wr + 1'b1;
			end
			if (pop) begin
				rd <= rd + 1'b1;
			end
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : tfs_fifo

// >>> core/tfs_crc32.sv
// Purpose: Byte-wide reflected CRC-32 accumulator for the frame check sequence
// Assumes: Data bytes enter least significant bit first
// Notes:   Register holds the raw remainder; complement gives the good FCS
`timescale 1ns/1ns
module tfs_crc32 (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_init,
	input  wire logic        i_en,
	input  wire logic [7:0]  i_data,
	output logic      [31:0] o_crc
);
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
		end
		return r;
	endfunction : crc_step

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_crc <= 32'hFFFFFFFF;
		end else if (i_init) begin
			o_crc <= 32'hFFFFFFFF;
		end else if (i_en) begin
			o_crc <= crc_step(o_crc, i_data);
		end
	end

endmodule : tfs_crc32

// >>> core/tfs_top.sv
// Purpose: Test frame source: frame generator that can own the PHY transmit path
// Assumes: APB slave, one frame byte per core clock, MAC inputs synchronous
// Notes:   Generator feeds a FIFO; the drain side sends a frame once it is full
`timescale 1ns/1ns
`include "tfs_cfg.svh"
module tfs_top #(
	parameter int unsigned P_BURST_FRAMES = `TFS_BURST_FRAMES
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_paddr,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic [7:0]  i_mac_txd,
	input  wire logic        i_mac_tx_en,
	input  wire logic        i_mac_tx_er,
	input  wire logic        i_rx_frame_done,
	input  wire logic        i_rx_crc_bad,
	output logic      [7:0]  o_phy_txd,
	output logic             o_phy_tx_en,
	output logic             o_phy_tx_er
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	localparam logic [9:0] GAP_SHORT = 10'(`TFS_GAP_SHORT_CYC);
	localparam logic [9:0] GAP_LONG  = 10'(`TFS_GAP_LONG_CYC);

	localparam logic [15:0] RST_CTRL = `TFS_RST_CTRL;
	// Reset settings as one constant, so the reset branch loads constants only
	localparam tfs_pkg::tfs_cfg_s CFG_RST = '{
		dur:     RST_CTRL[`TFS_B_DUR],
		len:     RST_CTRL[`TFS_B_LEN_HI:`TFS_B_LEN_LO],
		gap:     RST_CTRL[`TFS_B_GAP],
		da:      RST_CTRL[`TFS_B_DA_HI:`TFS_B_DA_LO],
		sa:      RST_CTRL[`TFS_B_SA_HI:`TFS_B_SA_LO],
		txer:    RST_CTRL[`TFS_B_TXER],
		badfcs:  RST_CTRL[`TFS_B_BADFCS],
		payload: `TFS_RST_PAYLOAD
	};

	// Idle cycles between frames, at one byte time per clock
	function automatic logic [9:0] gap_cycles(input logic long_gap);
		return long_gap ? GAP_LONG : GAP_SHORT;
	endfunction : gap_cycles

	function automatic logic [13:0] frame_len(input logic [1:0] code);
		case (code)
			2'b00:   return `TFS_LEN_00;
			2'b01:   return `TFS_LEN_01;
			2'b10:   return `TFS_LEN_10;
			default: return `TFS_LEN_11;
		endcase
	endfunction : frame_len

	function automatic logic [7:0] body_byte(input tfs_pkg::tfs_cfg_s c, input logic [13:0] i);
		logic [13:0] p;
		p = i - 14'd12;
		if (i == 14'd0) begin
			return {4'hF, c.da};
		end else if (i == 14'd6) begin
			return {4'hF, c.sa};
		end else if (i < 14'd12) begin
			return 8'hFF;
		end else begin
			return p[0] ? c.payload[7:0] : c.payload[15:8];
		end
	endfunction : body_byte

	function automatic logic apb_addr_is(input logic [7:0] a, input logic [5:0] idx);
		return a == {idx, 2'b00};
	endfunction : apb_addr_is

	function automatic tfs_pkg::tfs_cfg_s cfg_from(input logic [15:0] w, input logic [15:0] p);
		tfs_pkg::tfs_cfg_s c;
		c.dur     = w[`TFS_B_DUR];
		c.len     = w[`TFS_B_LEN_HI:`TFS_B_LEN_LO];
		c.gap     = w[`TFS_B_GAP];
		c.da      = w[`TFS_B_DA_HI:`TFS_B_DA_LO];
		c.sa      = w[`TFS_B_SA_HI:`TFS_B_SA_LO];
		c.txer    = w[`TFS_B_TXER];
		c.badfcs  = w[`TFS_B_BADFCS];
		c.payload = p;
		return c;
	endfunction : cfg_from

	////////////////////////////////////////////////////////////////////////////////
	// State and sub-blocks

	tfs_pkg::tfs_state_s s;
	tfs_pkg::tfs_state_s next_s;

	tfs_pkg::tfs_byte_s gen_byte;
	tfs_pkg::tfs_byte_s head;
	logic               gen_valid;
	logic               gen_ready;
	logic               push;
	logic               head_valid;
	logic               drain;
	logic               fifo_full;
	logic               flush;
	logic               crc_init;
	logic               crc_en;
	logic [31:0]        crc;
	logic [31:0]        fcs;
	logic [15:0]        ctrl_word;
	logic               setup;
	logic               access;
	logic [7:0]         crc_left;

	tfs_fifo #(
		.W ($bits(tfs_pkg::tfs_byte_s)),
		.D (`TFS_FIFO_DEPTH)
	) u_fifo (
		.i_core_clk  (i_core_clk),
		.i_rst_n     (i_rst_n),
		.i_flush     (flush),
		.i_in_valid  (gen_valid),
		.i_in_data   (gen_byte),
		.o_in_ready  (gen_ready),
		.o_out_valid (head_valid),
		.o_out_data  (head),
		.i_out_ready (drain),
		.o_full      (fifo_full)
	);

	tfs_crc32 u_crc (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_init     (crc_init),
		.i_en       (crc_en),
		.i_data     (gen_byte.data),
		.o_crc      (crc)
	);

	assign push = gen_valid && gen_ready;
	assign fcs  = s.sh.badfcs ? crc : ~crc;

	assign ctrl_word = {s.en, s.run, s.live.dur, s.live.len, s.live.gap, s.live.da,
		s.live.sa, s.live.txer, s.live.badfcs};
	assign setup     = i_psel && !i_penable;
	assign access    = i_psel && i_penable && s.pready;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s    = s;
		gen_valid = 1'b0;
		gen_byte  = '0;
		crc_init  = 1'b0;
		crc_en    = 1'b0;
		flush     = 1'b0;
		drain     = 1'b0;
		crc_left  = '0;

		// Settings are copied only on a fresh start of a run
		// Latched between frames only, so a quick re-arm cannot alter a frame in flight
		if (s.en && s.run && !s.run_seen && s.st == tfs_pkg::GEN_IDLE) begin
			next_s.sh       = s.live;
			next_s.run_seen = 1'b1;
			next_s.nfr      = '0;
		end
		if (!s.run || !s.en) begin
			next_s.run_seen = 1'b0;
		end

		gen_byte.er = s.sh.txer;
		case (s.st)
			tfs_pkg::GEN_IDLE: begin
				if (s.en && s.run && s.run_seen) begin
					next_s.st  = tfs_pkg::GEN_PRE;
					next_s.idx = '0;
					crc_init   = 1'b1;
				end
			end
			tfs_pkg::GEN_PRE: begin
				gen_valid     = 1'b1;
				gen_byte.data = (s.idx == 14'd7) ? `TFS_SFD : `TFS_PREAMBLE;
				if (push) begin
					next_s.idx = s.idx + 14'd1;
					if (s.idx == 14'd7) begin
						next_s.st  = tfs_pkg::GEN_DATA;
						next_s.idx = '0;
					end
				end
			end
			tfs_pkg::GEN_DATA: begin
				gen_valid     = 1'b1;
				gen_byte.data = body_byte(s.sh, s.idx);
				crc_en        = push;
				if (push) begin
					next_s.idx = s.idx + 14'd1;
					if (s.idx == frame_len(s.sh.len) - 14'd5) begin
						next_s.st  = tfs_pkg::GEN_FCS;
						next_s.idx = '0;
					end
				end
			end
			tfs_pkg::GEN_FCS: begin
				gen_valid     = 1'b1;
				gen_byte.data = fcs[{s.idx[1:0], 3'b000} +: 8];
				gen_byte.last = (s.idx[1:0] == 2'd3);
				if (push) begin
					next_s.idx = s.idx + 14'd1;
					if (s.idx[1:0] == 2'd3) begin
						next_s.st  = tfs_pkg::GEN_GAP;
						next_s.gap = gap_cycles(s.sh.gap);
						next_s.nfr = s.nfr + 25'd1;
						if (!s.sh.dur && (s.nfr == 25'(P_BURST_FRAMES - 1))) begin
							next_s.run = 1'b0;
						end
					end
				end
			end
			tfs_pkg::GEN_GAP: begin
				next_s.gap = s.gap - 10'd1;
				if (s.gap <= 10'd1) begin
					// Idle re-checks run, so a cleared run ends here, never mid-frame
					next_s.st = tfs_pkg::GEN_IDLE;
				end
			end
			default: begin
				next_s.st = tfs_pkg::GEN_IDLE;
			end
		endcase

		// Drain waits for a full FIFO so the frame leaves without holes
		if (!s.streaming) begin
			if (fifo_full) begin
				next_s.streaming = 1'b1;
			end
		end else begin
			drain = 1'b1;
			if (head_valid && head.last) begin
				next_s.streaming = 1'b0;
			end
		end

		if (s.en) begin
			next_s.txd   = (s.streaming && head_valid) ? head.data : 8'h00;
			next_s.tx_en = s.streaming && head_valid;
			next_s.tx_er = s.streaming && head_valid && head.er;
		end else begin
			next_s.txd   = i_mac_txd;
			next_s.tx_en = i_mac_tx_en;
			next_s.tx_er = i_mac_tx_er;
		end

		// Disable aborts at once: the generator must leave no trace on the line
		if (!s.en) begin
			next_s.st        = tfs_pkg::GEN_IDLE;
			next_s.streaming = 1'b0;
			flush            = 1'b1;
		end

		// Received CRC-error counter; a read removes only what it returned
		if (access && !i_pwrite && apb_addr_is(i_paddr, `TFS_IDX_CRCCNT)) begin
			crc_left = s.crccnt - s.prdata[7:0];
		end else begin
			crc_left = s.crccnt;
		end
		next_s.crccnt = crc_left;
		if (s.en && i_rx_frame_done && i_rx_crc_bad && crc_left != 8'hFF) begin
			next_s.crccnt = crc_left + 8'd1;
		end

		// APB: no wait states, answer registered in the setup cycle
		next_s.pready  = setup;
		next_s.pslverr = 1'b0;
		if (setup) begin
			next_s.prdata = 32'h00000000;
			if (apb_addr_is(i_paddr, `TFS_IDX_CTRL)) begin
				next_s.prdata = {16'h0000, ctrl_word};
			end else if (apb_addr_is(i_paddr, `TFS_IDX_PAYLOAD)) begin
				next_s.prdata = {16'h0000, s.live.payload};
			end else if (apb_addr_is(i_paddr, `TFS_IDX_CRCCNT)) begin
				next_s.prdata = {24'h000000, s.crccnt};
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		// Unmapped writes and writes to the read-only counter are dropped
		if (access && i_pwrite) begin
			if (apb_addr_is(i_paddr, `TFS_IDX_CTRL)) begin
				next_s.en   = i_pwdata[`TFS_B_EN];
				next_s.run  = i_pwdata[`TFS_B_RUN];
				next_s.live = cfg_from(i_pwdata[15:0], s.live.payload);
			end else if (apb_addr_is(i_paddr, `TFS_IDX_PAYLOAD)) begin
				next_s.live.payload = i_pwdata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s      <= '0;
			s.st   <= tfs_pkg::GEN_IDLE;
			s.live <= CFG_RST;
			s.sh   <= CFG_RST;
		end else begin
			s <= next_s;
		end
	end

	assign o_prdata    = s.prdata;
	assign o_pready    = s.pready;
	assign o_pslverr   = s.pslverr;
	assign o_phy_txd   = s.txd;
	assign o_phy_tx_en = s.tx_en;
	assign o_phy_tx_er = s.tx_er;

endmodule : tfs_top

// >>> testbench/tfs_top_asserts.sv
// Purpose: Port checks for the test frame source
// Assumes: Control writes are seen on the APB ports
// Notes:   Mirrors control to know enable and the latched address nibbles
`timescale 1ns/1ns
module tfs_top_asserts (
	input wire logic        i_core_clk,
	input wire logic        i_rst_n,
	input wire logic [7:0]  i_paddr,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic [7:0]  i_mac_txd,
	input wire logic        i_mac_tx_en,
	input wire logic        i_mac_tx_er,
	input wire logic        i_rx_frame_done,
	input wire logic        i_rx_crc_bad,
	input wire logic [7:0]  o_phy_txd,
	input wire logic        o_phy_tx_en,
	input wire logic        o_phy_tx_er
);
	logic [15:0] ctrl_m;
	logic [7:0]  sh_m;
	logic [13:0] len_c;
	wire         en_m = ctrl_m[15];
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_m <= 16'h0040;
			sh_m   <= 8'h10;
			len_c  <= 14'h0;
		end else begin
			len_c <= o_phy_tx_en ? len_c + 14'h1 : 14'h0;
			if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h74) begin
				ctrl_m <= i_pwdata[15:0];
				if (i_pwdata[15] && i_pwdata[14] && !ctrl_m[14]) begin
					sh_m <= i_pwdata[9:2];
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	mac_pass_a: assert property (
		!en_m && !$past(en_m) && !$past(en_m, 2) |-> o_phy_txd == $past(i_mac_txd)
		&& o_phy_tx_en == $past(i_mac_tx_en) && o_phy_tx_er == $past(i_mac_tx_er))
		else $error("PHY output is not the delayed MAC input");
	preamble_a: assert property (
		$rose(o_phy_tx_en) && en_m && $past(en_m) |-> (o_phy_txd == 8'h55) [*7]
		##1 o_phy_txd == 8'hD5) else $error("Bad preamble or delimiter");
	dest_byte_a: assert property (
		$rose(o_phy_tx_en) && en_m && $past(en_m) |-> ##8 o_phy_txd == {4'hF, sh_m[7:4]})
		else $error("Bad first destination byte");
	src_byte_a: assert property (
		$rose(o_phy_tx_en) && en_m && $past(en_m) |-> ##14 o_phy_txd == {4'hF, sh_m[3:0]})
		else $error("Bad first source byte");
	gap_min_a: assert property (
		$fell(o_phy_tx_en) && en_m |-> (!o_phy_tx_en || !en_m) [*8])
		else $error("Gap between frames too short");
	frame_len_a: assert property (
		$fell(o_phy_tx_en) && en_m |-> len_c == 14'd72 || len_c == 14'd133
		|| len_c == 14'd1526 || len_c == 14'd10008) else $error("Bad frame length");
	txer_steady_a: assert property (
		o_phy_tx_en && $past(o_phy_tx_en) && en_m && $past(en_m, 2) |-> $stable(o_phy_tx_er))
		else $error("Error marking changed within a frame");
	crc_width_a: assert property (
		i_psel && i_penable && o_pready && i_paddr == 8'h5C |-> o_prdata[31:8] == 24'h0)
		else $error("Counter read wider than eight bits");
endmodule : tfs_top_asserts

bind tfs_top tfs_top_asserts u_asserts (
	.i_core_clk      (i_core_clk),
	.i_rst_n         (i_rst_n),
	.i_paddr         (i_paddr),
	.i_psel          (i_psel),
	.i_penable       (i_penable),
	.i_pwrite        (i_pwrite),
	.i_pwdata        (i_pwdata),
	.o_prdata        (o_prdata),
	.o_pready        (o_pready),
	.o_pslverr       (o_pslverr),
	.i_mac_txd       (i_mac_txd),
	.i_mac_tx_en     (i_mac_tx_en),
	.i_mac_tx_er     (i_mac_tx_er),
	.i_rx_frame_done (i_rx_frame_done),
	.i_rx_crc_bad    (i_rx_crc_bad),
	.o_phy_txd       (o_phy_txd),
	.o_phy_tx_en     (o_phy_tx_en),
	.o_phy_tx_er     (o_phy_tx_er)
);

// >>> testbench/tfs_link_partner.sv
// Purpose: Link partner: takes PHY transmit bytes, sends receive reports
// Assumes: One byte per clock while transmit enable is high
// Notes:   Receive reports go out only when the bench asks for them
`timescale 1ns/1ns
module tfs_link_partner (
	input  wire logic       i_core_clk,
	input  wire logic [7:0] i_txd,
	input  wire logic       i_tx_en,
	input  wire logic       i_tx_er,
	output logic            o_rx_frame_done,
	output logic            o_rx_crc_bad
);
	logic [7:0] buf_q [0:10015];
	int         n;
	int         flen;
	int         frames;
	int         gap;
	int         gap_min;
	logic       er_all;
	logic       er_any;
	task automatic clear();
		n       = 0;
		frames  = 0;
		gap_min = 100000;
		er_all  = 1'b1;
		er_any  = 1'b0;
	endtask : clear
	task automatic pulse(input logic bad);
		@(posedge i_core_clk);
		o_rx_frame_done <= 1'b1;
		o_rx_crc_bad    <= bad;
		@(posedge i_core_clk);
		o_rx_frame_done <= 1'b0;
		o_rx_crc_bad    <= 1'b0;
	endtask : pulse
	initial begin
		o_rx_frame_done = 1'b0;
		o_rx_crc_bad    = 1'b0;
		gap             = 0;
		clear();
	end
	always @(posedge i_core_clk) begin
		if (i_tx_en) begin
			buf_q[n] <= i_txd;
			n        <= n + 1;
			er_any   <= er_any | i_tx_er;
			er_all   <= er_all & i_tx_er;
			if (n == 0 && frames > 0 && gap < gap_min)
				gap_min <= gap;
		end else if (n > 0) begin
			flen   <= n;
			frames <= frames + 1;
			n      <= 0;
			gap    <= 1;
		end else
			gap <= gap + 1;
	end
endmodule : tfs_link_partner

// >>> testbench/tfs_top_tb.sv
// Purpose: Self-checking bench for the test frame source
// Assumes: Burst count shortened through P_BURST_FRAMES
// Notes:   Frames are judged byte by byte against values built here
`timescale 1ns/1ns
`include "tfs_cfg.svh"
module tfs_top_tb;
	localparam int unsigned BURST = 3;
	localparam logic [7:0]  A_CTRL = {`TFS_IDX_CTRL, 2'b00};
	localparam logic [7:0]  A_PAY = {`TFS_IDX_PAYLOAD, 2'b00};
	localparam logic [7:0]  A_CRC = {`TFS_IDX_CRCCNT, 2'b00};
	logic        clk;
	logic        rst_n;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  mtxd;
	logic        mtx_en;
	logic        mtx_er;
	logic        rx_done;
	logic        rx_bad;
	logic [7:0]  ptxd;
	logic        ptx_en;
	logic        ptx_er;
	logic [31:0] rd;
	logic        err;
	int          error_cnt;
	int          compares;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	tfs_top #(.P_BURST_FRAMES(BURST)) DUT (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_paddr(paddr), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_mac_txd(mtxd), .i_mac_tx_en(mtx_en),
		.i_mac_tx_er(mtx_er), .i_rx_frame_done(rx_done), .i_rx_crc_bad(rx_bad),
		.o_phy_txd(ptxd), .o_phy_tx_en(ptx_en), .o_phy_tx_er(ptx_er));
	tfs_link_partner link (.i_core_clk(clk), .i_txd(ptxd), .i_tx_en(ptx_en),
		.i_tx_er(ptx_er), .o_rx_frame_done(rx_done), .o_rx_crc_bad(rx_bad));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("Compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic limit(input int k, input int lim);
		if (k >= lim) begin
			error_cnt++;
			$display("Error t=%0t wait timed out", $time);
			tally_and_finish();
		end
	endtask : limit
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t register got %h want %h", $time, got, exp);
		end
	endtask : cmp_reg
	task automatic cmp_wire(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t line got %h want %h", $time, got, exp);
		end
	endtask : cmp_wire
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int k;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1 && penable === 1'b1)
				break;
		end
		limit(k, 20);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic start(input logic [15:0] c);
		apb(1'b1, A_CTRL, c);
		apb(1'b1, A_CTRL, c | 16'h4000);
	endtask : start
	task automatic wait_frames(input int f);
		int k;
		for (k = 0; k < 40000 && link.frames < f; k++)
			@(posedge clk);
		limit(k, 40000);
	endtask : wait_frames
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
		int i;
		for (i = 0; i < 8; i++)
			c = (c[0] ^ d[i]) ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		return c;
	endfunction : crc_step
	task automatic check_frame(input int len, input logic [3:0] da, input logic [3:0] sa,
		input logic [15:0] pl, input logic bad);
		logic [31:0] crc;
		logic [7:0]  e;
		int          j;
		crc = 32'hFFFFFFFF;
		cmp_wire(link.flen, len + 8);
		for (j = 0; j < 8; j++)
			cmp_wire(link.buf_q[j], j < 7 ? `TFS_PREAMBLE : `TFS_SFD);
		for (j = 0; j < len - 4; j++) begin
			e = (j == 0) ? {4'hF, da} : (j == 6) ? {4'hF, sa} : (j < 12) ? 8'hFF
				: (j[0] ? pl[7:0] : pl[15:8]);
			cmp_wire(link.buf_q[j + 8], e);
			crc = crc_step(crc, e);
		end
		if (!bad)
			crc = ~crc;
		for (j = 0; j < 4; j++)
			cmp_wire(link.buf_q[len + 4 + j], crc[8*j +: 8]);
	endtask : check_frame
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		apb(1'b1, 8'h00, 16'hFFFF);
		apb(1'b0, 8'h00, 16'h0000);
		cmp_reg({err, rd[30:0]}, 32'h80000000);
		apb(1'b0, A_CTRL, 16'h0000);
		cmp_reg(rd, 32'h00000040);
		apb(1'b0, A_PAY, 16'h0000);
		cmp_reg(rd, 32'h00000000);
		$display("Test reset done");
	endtask : t_reset
	task automatic t_pass();
		int i;
		apb(1'b1, A_CTRL, 16'h6040);
		repeat (20) @(posedge clk);
		cmp_wire(link.frames, 0);
		for (i = 0; i < 7; i++) begin
			@(posedge clk);
			mtxd   <= 8'h30 + i[7:0];
			mtx_en <= i[0];
			mtx_er <= i[1];
			@(negedge clk);
			if (i > 0)
				cmp_wire({ptx_er, ptx_en, ptxd}, {i[1] ^ (i[0] == 0), ~i[0], 8'h2F + i[7:0]});
		end
		mtx_en <= 1'b0;
		apb(1'b1, A_CTRL, 16'h0040);
		link.clear();
		$display("Test pass-through done");
	endtask : t_pass
	task automatic t_frame();
		int i;
		apb(1'b1, A_PAY, 16'hA5C3);
		apb(1'b0, A_PAY, 16'h0000);
		cmp_reg(rd, 32'h0000A5C3);
		start(16'hA96A);
		mtx_en <= 1'b1;
		mtxd   <= 8'h11;
		wait_frames(2);
		check_frame(64, 4'h5, 4'hA, 16'hA5C3, 1'b0);
		apb(1'b1, A_CTRL, 16'hE028);
		wait_frames(4);
		check_frame(64, 4'h5, 4'hA, 16'hA5C3, 1'b0);
		for (i = 0; i < 100 && ptx_en !== 1'b1; i++)
			@(negedge clk);
		limit(i, 100);
		apb(1'b1, A_CTRL, 16'hA028);
		wait_frames(5);
		repeat (60) @(posedge clk);
		cmp_wire(link.frames, 32'h5);
		cmp_wire(link.n, 32'h0);
		check_frame(64, 4'h5, 4'hA, 16'hA5C3, 1'b0);
		cmp_wire({link.er_all, link.gap_min >= 10}, 2'b11);
		mtx_en <= 1'b0;
		$display("Test frame done");
	endtask : t_frame
	task automatic t_badfcs();
		link.clear();
		start(16'hA4F1);
		wait_frames(2);
		check_frame(125, 4'h3, 4'hC, 16'hA5C3, 1'b1);
		cmp_wire({link.er_any, link.gap_min >= 820}, 2'b01);
		apb(1'b1, A_CTRL, 16'h0040);
		$display("Test bad check sequence done");
	endtask : t_badfcs
	task automatic t_burst();
		int l;
		for (l = 2; l < 4; l++) begin
			link.clear();
			start(l == 2 ? 16'h9040 : 16'h9840);
			wait_frames(BURST);
			check_frame(l == 2 ? 1518 : 10000, 4'h1, 4'h0, 16'hA5C3, 1'b0);
			repeat (40) @(posedge clk);
			cmp_wire(link.frames, BURST);
			cmp_wire(link.n, 32'h0);
			apb(1'b0, A_CTRL, 16'h0000);
			cmp_reg(rd[14], 1'b0);
			apb(1'b1, A_CTRL, 16'h8040);
		end
		$display("Test burst done");
	endtask : t_burst
	task automatic t_crc();
		int i;
		for (i = 0; i < 3; i++)
			link.pulse(1'b1);
		link.pulse(1'b0);
		apb(1'b0, A_CRC, 16'h0000);
		cmp_reg(rd, 32'h00000003);
		for (i = 0; i < 260; i++)
			link.pulse(1'b1);
		apb(1'b0, A_CRC, 16'h0000);
		cmp_reg(rd, 32'h000000FF);
		apb(1'b1, A_CTRL, 16'h0040);
		link.pulse(1'b1);
		apb(1'b0, A_CRC, 16'h0000);
		cmp_reg(rd, 32'h00000000);
		$display("Test receive counter done");
	endtask : t_crc
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		error_cnt = 0;
		compares  = 0;
		rst_n     = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		mtxd      = 8'h00;
		mtx_en    = 1'b0;
		mtx_er    = 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_pass();
		t_frame();
		t_badfcs();
		t_burst();
		t_crc();
		tally_and_finish();
	end
endmodule : tfs_top_tb
